// file: core/pmic_ctl_regs.sv
// Purpose: Control, resume flag and unlock key registers of a power manager.
// Assumes: The serial interface decodes a transfer into one-cycle rd_en/wr_en strobes with addr and wdata.
// Notes: Read data appears one cycle after rd_en and holds until the next read.
`timescale 1ns/10ps
`default_nettype none
`include "pmic_ctl_regs.svh"

module pmic_ctl_regs (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire pmic_ctl_pkg::byte_t addr,
  input wire pmic_ctl_pkg::byte_t wdata,
  output var pmic_ctl_pkg::byte_t rdata,
  input wire logic power_fail_out_n,
  input wire pmic_ctl_pkg::pwr_state_t pwr_state,
  input wire pmic_ctl_pkg::byte_t suspend_enables,
  output var logic power_fail_shutdown_en,
  output var logic coin_cell_acq_start,
  output var logic power_fail_off_req,
  output var logic unlock_key_wr,
  output var pmic_ctl_pkg::byte_t unlock_key_value
);
  import pmic_ctl_pkg::*;

  // ==========================================================================
  // Register state
  logic shut_en_r, shut_en_nxt;
  logic acq_r, acq_nxt;
  logic off_req_r, off_req_nxt;
  byte_t flags_r, flags_nxt;
  byte_t key_r, key_nxt;
  logic key_wr_r, key_wr_nxt;
  byte_t rdata_r, rdata_nxt;
  pwr_state_t prev_state_r, prev_state_nxt;
  logic wr_ctl, wr_key, power_up;

  function automatic logic hit(input byte_t a, input byte_t ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================================
  // Address decode
  always_comb begin
    wr_ctl = wr_en && hit(addr, `POWER_CONTROL_OFS);
    wr_key = wr_en && hit(addr, `UNLOCK_KEY_OFS);
    power_up = (pwr_state == PWR_ACTIVE) && (prev_state_r != PWR_ACTIVE);
  end

  // ==========================================================================
  // Control register and power-fail shutdown request
  always_comb begin
    shut_en_nxt = shut_en_r;
    if (wr_ctl) begin
      shut_en_nxt = wdata[`POWER_FAIL_SHUTDOWN_EN_BIT];
    end
    // The start bit lives for one cycle only, which is the trigger pulse itself.
    acq_nxt = wr_ctl && wdata[`COIN_CELL_ACQ_START_BIT];
    // The request is gated by the enable so a disabled shutdown leaves the state alone.
    off_req_nxt = shut_en_r && !power_fail_out_n;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shut_en_r <= 1'b0;
      acq_r <= 1'b0;
      off_req_r <= 1'b0;
    end else begin
      shut_en_r <= shut_en_nxt;
      acq_r <= acq_nxt;
      off_req_r <= off_req_nxt;
    end
  end

  // ==========================================================================
  // Resume flags
  always_comb begin
    prev_state_nxt = pwr_state;
    flags_nxt = flags_r;
    if (power_up) begin
      // Bit order of suspend_enables is out3,out2,out1,linreg,conv4..conv1.
      flags_nxt = (prev_state_r == PWR_SUSPEND) ? suspend_enables : `RESUME_FLAGS_RST;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= `RESUME_FLAGS_RST;
      // Reset counts as OFF, so the first entry to ACTIVE clears the flags.
      prev_state_r <= PWR_OFF;
    end else begin
      flags_r <= flags_nxt;
      prev_state_r <= prev_state_nxt;
    end
  end

  // ==========================================================================
  // Unlock key
  always_comb begin
    key_nxt = wr_key ? wdata : key_r;
    // The strobe tells the protection, seal and default logic that a key byte arrived.
    key_wr_nxt = wr_key;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      key_r <= `UNLOCK_KEY_RST;
      key_wr_r <= 1'b0;
    end else begin
      key_r <= key_nxt;
      key_wr_r <= key_wr_nxt;
    end
  end

  // ==========================================================================
  // Read data
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_en) begin
      case (addr)
        `POWER_CONTROL_OFS: rdata_nxt = {6'h00, shut_en_r, acq_r};
        `RESUME_FLAGS_OFS: rdata_nxt = flags_r;
        `UNLOCK_KEY_OFS: rdata_nxt = `READ_ZERO;
        default: rdata_nxt = `READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `READ_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdata = rdata_r;
  assign power_fail_shutdown_en = shut_en_r;
  assign coin_cell_acq_start = acq_r;
  assign power_fail_off_req = off_req_r;
  assign unlock_key_wr = key_wr_r;
  assign unlock_key_value = key_r;

  // ==========================================================================
  // Checks
  sequence ctl_write_one_s;
    wr_en && addr == `POWER_CONTROL_OFS && wdata[0];
  endsequence

  shutdown_gated_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !shut_en_r |=> !power_fail_off_req) else $error("shutdown request without enable");
  shutdown_taken_a: assert property (@(posedge mclk) disable iff (!rst_n)
    shut_en_r && !power_fail_out_n |=> power_fail_off_req) else $error("shutdown request missing");
  acq_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctl_write_one_s |=> coin_cell_acq_start) else $error("acquisition not started");
  acq_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctl_write_one_s ##1 !wr_ctl |=> !coin_cell_acq_start) else $error("acquisition bit stuck");
  acq_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    coin_cell_acq_start && !(wr_ctl && wdata[0]) |=> !coin_cell_acq_start) else $error("acquisition bit not cleared");
  flags_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !power_up |=> $stable(flags_r)) else $error("resume flags changed without power-up");
  flags_resume_a: assert property (@(posedge mclk) disable iff (!rst_n)
    power_up && prev_state_r == PWR_SUSPEND |=> flags_r == $past(suspend_enables)) else $error("flags not set");
  flags_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    power_up && prev_state_r == PWR_OFF |=> flags_r == 8'h00) else $error("flags not cleared");
  key_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_en && addr == `UNLOCK_KEY_OFS |=> rdata == 8'h00) else $error("unlock key read not zero");
  ctl_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_en && addr == `POWER_CONTROL_OFS |=> rdata[7:2] == 6'h00) else $error("reserved bits not zero");
  key_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_en && addr == `UNLOCK_KEY_OFS |=> unlock_key_wr && unlock_key_value == $past(wdata))
    else $error("unlock key not stored");

  // ==========================================================================
  // Decode for the checks
  // The checks keep their own decode so a slip in the strobes above cannot hide itself.
  logic rd_ctl_c, rd_flags_c, rd_key_c, rd_other_c, wr_ctl_c, wr_key_c, wr_flags_c;
  always_comb begin
    rd_ctl_c = rd_en && hit(addr, `POWER_CONTROL_OFS);
    rd_flags_c = rd_en && hit(addr, `RESUME_FLAGS_OFS);
    rd_key_c = rd_en && hit(addr, `UNLOCK_KEY_OFS);
    rd_other_c = rd_en && !rd_ctl_c && !rd_flags_c && !rd_key_c;
    wr_ctl_c = wr_en && hit(addr, `POWER_CONTROL_OFS);
    wr_key_c = wr_en && hit(addr, `UNLOCK_KEY_OFS);
    wr_flags_c = wr_en && hit(addr, `RESUME_FLAGS_OFS);
  end

  // ==========================================================================
  // Check sequences
  sequence ctl_write_zero_s;
    wr_ctl_c && !wdata[`COIN_CELL_ACQ_START_BIT];
  endsequence

  sequence key_write_s;
    wr_key_c;
  endsequence

  // A wake is seen as two sampled states in a row, independent of the design's own history register.
  sequence wake_from_suspend_s;
    pwr_state == PWR_SUSPEND ##1 pwr_state == PWR_ACTIVE;
  endsequence

  sequence wake_from_off_s;
    pwr_state == PWR_OFF ##1 pwr_state == PWR_ACTIVE;
  endsequence

  sequence power_fail_armed_s;
    shut_en_r && !power_fail_out_n;
  endsequence

  // ==========================================================================
  // Reset values
  // These carry no disable, so that they look at the registers while reset is held.
  ctl_reset_a: assert property (@(posedge mclk)
    !rst_n |-> !power_fail_shutdown_en && !coin_cell_acq_start && !power_fail_off_req)
    else $error("control register not cleared by reset");

  flags_reset_a: assert property (@(posedge mclk)
    !rst_n |-> flags_r == `RESUME_FLAGS_RST) else $error("resume flags not cleared by reset");

  key_reset_a: assert property (@(posedge mclk)
    !rst_n |-> unlock_key_value == `UNLOCK_KEY_RST && !unlock_key_wr) else $error("unlock key not cleared by reset");

  // ==========================================================================
  // Control checks
  acq_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctl_write_zero_s |=> !coin_cell_acq_start) else $error("acquisition started by a zero");

  acq_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_ctl_c |=> !coin_cell_acq_start) else $error("acquisition started without a write");

  shut_en_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_ctl_c |=> power_fail_shutdown_en == $past(wdata[`POWER_FAIL_SHUTDOWN_EN_BIT]))
    else $error("shutdown enable not written");

  shut_en_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_ctl_c |=> $stable(power_fail_shutdown_en)) else $error("shutdown enable changed without a write");

  off_req_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    power_fail_out_n |=> !power_fail_off_req) else $error("shutdown request without power fail");

  // A held power fail must keep the request up, not just raise it once.
  off_req_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
    power_fail_armed_s ##1 power_fail_armed_s |=> power_fail_off_req) else $error("shutdown request dropped");

  // ==========================================================================
  // Resume flag checks
  flags_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_flags_c && !power_up |=> $stable(flags_r)) else $error("resume flags changed by a write");

  flags_wake_suspend_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wake_from_suspend_s |=> flags_r == $past(suspend_enables)) else $error("flags wrong after suspend wake");

  flags_wake_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wake_from_off_s |=> flags_r == `RESUME_FLAGS_RST) else $error("flags wrong after off wake");

  flags_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wake_from_suspend_s |=> flags_r[7] == $past(suspend_enables[7]) && flags_r[4] == $past(suspend_enables[4])
      && flags_r[0] == $past(suspend_enables[0])) else $error("flag bit order wrong");

  flags_steady_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pwr_state == PWR_ACTIVE && prev_state_r == PWR_ACTIVE |=> $stable(flags_r)) else $error("flags moved while active");

  flags_no_wake_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pwr_state != PWR_ACTIVE |=> $stable(flags_r)) else $error("flags moved outside a wake");

  // ==========================================================================
  // Read checks
  flags_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_flags_c |=> rdata == $past(flags_r)) else $error("resume flag read wrong");

  ctl_read_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_ctl_c |=> rdata[1] == $past(shut_en_r) && rdata[0] == $past(acq_r)) else $error("control read wrong");

  unmapped_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_other_c |=> rdata == `READ_ZERO) else $error("unmapped read not zero");

  // ==========================================================================
  // Unlock key checks
  key_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_key_c |=> !unlock_key_wr) else $error("unlock strobe without a write");

  key_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_key_c |=> $stable(unlock_key_value)) else $error("unlock key changed without a write");

  // Reading right after a write is where a leak of the stored key would show.
  key_read_last_a: assert property (@(posedge mclk) disable iff (!rst_n)
    key_write_s ##[1:3] rd_key_c |=> rdata == `READ_ZERO) else $error("unlock key leaked on read");
endmodule
`default_nettype wire

// file: core/pmic_ctl_regs.svh
// Purpose: Offsets, field positions and reset values of the control, resume and unlock registers.
// Assumes: Registers are eight bits wide and reached by an eight-bit subaddress.
// Notes: Definitions only.
`ifndef PMIC_CTL_REGS_SVH
`define PMIC_CTL_REGS_SVH

// ==========================================================================
// Register offsets
`define POWER_CONTROL_OFS 8'h06
`define RESUME_FLAGS_OFS 8'h07
`define UNLOCK_KEY_OFS 8'h10

// ==========================================================================
// Field positions
`define COIN_CELL_ACQ_START_BIT 0
`define POWER_FAIL_SHUTDOWN_EN_BIT 1

// ==========================================================================
// Reset values
`define POWER_CONTROL_RST 8'h00
`define RESUME_FLAGS_RST 8'h00
`define UNLOCK_KEY_RST 8'h00
`define READ_ZERO 8'h00

`endif

// file: core/pmic_ctl_pkg.sv
// Purpose: Types shared by the control, resume and unlock register block.
// Assumes: Nothing beyond the register header.
// Notes: Power states are the sequencer view seen by this block.
package pmic_ctl_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_ACTIVE,
    PWR_SUSPEND
  } pwr_state_t;
endpackage

// file: test/pmic_host_model.sv
// Purpose: Host model issuing single-byte register reads and writes.
// Assumes: One-cycle strobes launched at the falling edge of mclk.
// Notes: Idle address is inverted after every access and idle data after a write only, so a stale value cannot pass.
`timescale 1ns/10ps
`default_nettype none
module pmic_host_model (
  input wire logic mclk,
  output var logic rd_en,
  output var logic wr_en,
  output var pmic_ctl_pkg::byte_t addr,
  output var pmic_ctl_pkg::byte_t wdata,
  input wire pmic_ctl_pkg::byte_t rdata
);
  import pmic_ctl_pkg::*;
  initial begin
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic wr(input byte_t a, input byte_t d);
    @(negedge mclk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk);
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic rd(input byte_t a, output byte_t d);
    @(negedge mclk);
    rd_en = 1'b1;
    addr = a;
    @(negedge mclk);
    rd_en = 1'b0;
    addr = ~a;
    d = rdata;
  endtask
endmodule
`default_nettype wire

// file: test/pmic_control_flag_unlock_regs_test.sv
// Purpose: Self-checking bench of the control, resume flag and unlock registers.
// Assumes: Bench drives inputs at the falling edge.
// Notes: Prints only mismatches and the verdict.
`timescale 1ns/10ps
`default_nettype none
`include "pmic_ctl_regs.svh"
module pmic_control_flag_unlock_regs_test;
  import pmic_ctl_pkg::*;
  logic mclk, rst_n, rd_en, wr_en, pf_n, shut_en, acq, off_req, key_wr;
  byte_t addr, wdata, rdata, susp_en, key_val, v;
  pwr_state_t pwr_state;
  int error_cnt = 0;
  int checks = 0;
  pmic_host_model host (.mclk(mclk), .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata(rdata));
  pmic_ctl_regs dut (.mclk(mclk), .rst_n(rst_n), .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .power_fail_out_n(pf_n), .pwr_state(pwr_state), .suspend_enables(susp_en),
    .power_fail_shutdown_en(shut_en), .coin_cell_acq_start(acq), .power_fail_off_req(off_req),
    .unlock_key_wr(key_wr), .unlock_key_value(key_val));
  task automatic chk(input byte_t seen, input byte_t exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ==========================================================================
  // Watchdog: the sequence needs well under a hundred cycles.
  initial begin
    #20000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    pf_n = 1'b1;
    pwr_state = PWR_OFF;
    susp_en = 8'h00;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    host.rd(`POWER_CONTROL_OFS, v);
    chk(v, `POWER_CONTROL_RST);
    host.rd(`RESUME_FLAGS_OFS, v);
    chk(v, `RESUME_FLAGS_RST);
    host.rd(8'h20, v);
    chk(v, 8'h00);
    pf_n = 1'b0;
    @(negedge mclk);
    chk({7'h00, off_req}, 8'h00);
    pf_n = 1'b1;
    host.wr(`POWER_CONTROL_OFS, 8'hFF);
    chk({7'h00, acq}, 8'h01);
    chk({7'h00, shut_en}, 8'h01);
    @(negedge mclk);
    chk({7'h00, acq}, 8'h00);
    host.rd(`POWER_CONTROL_OFS, v);
    chk(v, 8'h02);
    host.wr(`POWER_CONTROL_OFS, 8'h02);
    chk({7'h00, acq}, 8'h00);
    pf_n = 1'b0;
    @(negedge mclk);
    chk({7'h00, off_req}, 8'h01);
    pf_n = 1'b1;
    host.wr(`UNLOCK_KEY_OFS, 8'hA5);
    chk({7'h00, key_wr}, 8'h01);
    chk(key_val, 8'hA5);
    host.rd(`UNLOCK_KEY_OFS, v);
    chk(v, `READ_ZERO);
    susp_en = 8'hA6;
    pwr_state = PWR_SUSPEND;
    @(negedge mclk);
    pwr_state = PWR_ACTIVE;
    @(negedge mclk);
    susp_en = 8'h5A;
    host.wr(`RESUME_FLAGS_OFS, 8'hFF);
    host.rd(`RESUME_FLAGS_OFS, v);
    chk(v, 8'hA6);
    pwr_state = PWR_OFF;
    @(negedge mclk);
    pwr_state = PWR_ACTIVE;
    @(negedge mclk);
    host.rd(`RESUME_FLAGS_OFS, v);
    chk(v, 8'h00);
    host.wr(`POWER_CONTROL_OFS, 8'h02);
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    chk({6'h00, shut_en, acq}, `POWER_CONTROL_RST);
    chk(key_val, `UNLOCK_KEY_RST);
    host.rd(`POWER_CONTROL_OFS, v);
    chk(v, `POWER_CONTROL_RST);
    wrap_up();
  end
endmodule
`default_nettype wire
